//--- design/vmcu_element_test.sv
/*
 * Element tester: decides whether one source element meets the selected
 * condition. Purely combinational; the sequencer registers the result.
 */
`timescale 1ns/1ps

module vmcu_element_test
    import vmcu_pkg::*;
(
    vmcu_test_if.tester tif
);

    always_comb begin
        unique case (tif.test)
            VMCU_TEST_ZERO:    tif.hit = (tif.element == 64'h0);
            VMCU_TEST_NONZERO: tif.hit = (tif.element != 64'h0);
            // A zero element has a clear sign bit and so counts as positive.
            VMCU_TEST_POS:     tif.hit = ~tif.element[VMCU_SIGN_BIT];
            VMCU_TEST_NEG:     tif.hit = tif.element[VMCU_SIGN_BIT];
        endcase
    end

endmodule

//--- design/vmcu_mask_compress.sv
/*
 * Vector mask and compress index unit. Accepts one instruction at a time
 * from issue logic, consumes source elements as they stream in, builds a
 * 64-bit element flag register and optionally writes a compressed index
 * list. Assumes issue logic and the register file run on the same clock
 * and honour issue_ready and the register reservations themselves.
 */
`timescale 1ns/1ps

module vmcu_mask_compress
    import vmcu_pkg::*;
(
    input  wire logic                           clock,
    input  wire logic                           reset_n,
    input  wire logic                           issue_valid,
    output logic                                issue_ready,
    input  wire logic [2:0]                     issue_designator,
    input  wire logic [vmcu_pkg::VMCU_CNT_W-1:0] element_count_register,
    input  wire logic                           src_valid,
    output logic                                src_ready,
    input  wire logic [vmcu_pkg::VMCU_ELEM_W-1:0] tested_source_vector,
    output logic [vmcu_pkg::VMCU_IDX_W-1:0]     src_index,
    output logic                                src_release,
    output logic                                idx_wr_en,
    output logic [vmcu_pkg::VMCU_IDX_W-1:0]     idx_wr_addr,
    output logic [vmcu_pkg::VMCU_ELEM_W-1:0]    index_destination_vector,
    output logic                                dest_ready,
    output logic [vmcu_pkg::VMCU_ELEM_W-1:0]    element_flag_register,
    output logic                                mask_ready,
    output logic                                mask_ready_dep
);

    import vmcu_pkg::*;

    // Taps of the post-release shift line, counted from the unit-free point.
    localparam int DEP_LEN  = int'(VMCU_MASK_DEP_CP - VMCU_UNIT_FREE_CP);
    localparam int DEST_LEN = int'(VMCU_DEST_RDY_CP - VMCU_UNIT_FREE_CP);

    ////////////////////////////////////////////////////////////////////////////
    vmcu_state_e              state;
    logic [VMCU_CNT_W-1:0]    count;
    logic [VMCU_CNT_W-1:0]    elem;
    logic [VMCU_IDX_W-1:0]    wr_ptr;
    logic [1:0]               test;
    logic                     compress;
    logic [VMCU_TIME_W-1:0]   elapsed;
    logic [VMCU_TIME_W-1:0]   next_elapsed;
    logic [VMCU_TIME_W-1:0]   limit;
    logic [DEST_LEN-1:0]      late_free;
    logic [DEST_LEN-1:0]      late_comp;
    logic                     issue_fire;
    logic                     consume;
    logic                     hit;
    logic                     unit_free;

    vmcu_test_if tif ();

    assign tif.element = tested_source_vector;
    assign tif.test    = test;
    assign hit         = tif.hit;

    vmcu_element_test u_test (
        .tif (tif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // A new instruction is only taken once the previous one has left the unit.
    assign issue_ready = (state == VMCU_IDLE);
    assign issue_fire  = issue_valid && issue_ready;
    assign src_ready   = (state == VMCU_SCAN) && (elem < count);
    assign consume     = src_ready && src_valid;

    // Elapsed periods only advance with data while elements remain, so a
    // stalled chain stretches every later deadline by the same amount.
    always_comb begin
        next_elapsed = elapsed;
        if (state == VMCU_SCAN) begin
            if (elem < count) begin
                next_elapsed = consume ? elapsed + VMCU_ISSUE_CP : elapsed;
            end else begin
                next_elapsed = elapsed + VMCU_ISSUE_CP;
            end
        end else if (state == VMCU_DRAIN) begin
            next_elapsed = elapsed + VMCU_ISSUE_CP;
        end
    end

    assign limit     = {1'b0, count};
    assign unit_free = (state != VMCU_IDLE) && (next_elapsed == limit + VMCU_UNIT_FREE_CP);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= VMCU_IDLE;
        end else begin
            unique case (state)
                VMCU_IDLE:  if (issue_fire) begin
                    state <= VMCU_SCAN;
                end
                VMCU_SCAN:  if (unit_free) begin
                    state <= VMCU_IDLE;
                end else if (elem >= count) begin
                    state <= VMCU_DRAIN;
                end
                VMCU_DRAIN: if (unit_free) begin
                    state <= VMCU_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count    <= VMCU_CNT_RESET;
            test     <= VMCU_TEST_ZERO;
            compress <= 1'b0;
        end else if (issue_fire) begin
            count    <= element_count_register;
            test     <= issue_designator[1:0];
            compress <= issue_designator[VMCU_COMPRESS_BIT];
        end
    end

    // The issue period itself counts, so the clock starts at one.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            elapsed <= VMCU_TIME_RESET;
        end else if (issue_fire) begin
            elapsed <= VMCU_ISSUE_CP;
        end else begin
            elapsed <= next_elapsed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Element walk and mask build. Elements past the count are never taken,
    // because src_ready drops there, which keeps their mask bits at zero.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            elem                  <= VMCU_CNT_RESET;
            element_flag_register <= VMCU_MASK_RESET;
        end else if (issue_fire) begin
            elem                  <= VMCU_CNT_RESET;
            // Clearing at issue leaves every untested element's bit at zero.
            element_flag_register <= VMCU_MASK_RESET;
        end else if (consume) begin
            elem <= elem + 7'h01;
            // Same mask for both forms; only the low test bits reach the tester.
            element_flag_register[VMCU_SIGN_BIT - src_index] <= hit;
        end
    end

    assign src_index = elem[VMCU_IDX_W-1:0];

    // Compress index writes; an instruction with no hits writes nothing.
    // The pointer simply wraps after a full list of hits; no write follows.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr                   <= {VMCU_IDX_W{1'b0}};
            idx_wr_en                <= 1'b0;
            idx_wr_addr              <= {VMCU_IDX_W{1'b0}};
            index_destination_vector <= VMCU_MASK_RESET;
        end else begin
            idx_wr_en <= consume && compress && hit;
            if (issue_fire) begin
                wr_ptr <= {VMCU_IDX_W{1'b0}};
            end else if (consume && compress && hit) begin
                wr_ptr                   <= wr_ptr + 6'h01;
                idx_wr_addr              <= wr_ptr;
                index_destination_vector <= {58'h0, elem[VMCU_IDX_W-1:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readiness pulses for the current instruction.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            src_release <= 1'b0;
            mask_ready  <= 1'b0;
        end else begin
            src_release <= (state != VMCU_IDLE) && !issue_fire
                           && (next_elapsed == limit + VMCU_SRC_FREE_CP);
            mask_ready  <= (state != VMCU_IDLE) && !issue_fire
                           && (next_elapsed == limit + VMCU_MASK_RDY_CP);
        end
    end

    // Deadlines past the unit-free point ride a shift line, so the unit can
    // take the next instruction at count plus four. Unit-free points lie at
    // least four periods apart and each one owns a stage, so a short follower
    // can never swallow the destination-ready pulse of the one before it.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            late_free <= '0;
            late_comp <= '0;
        end else begin
            late_free[0] <= unit_free;
            late_comp[0] <= compress;
            for (int s = 1; s < DEST_LEN; s++) begin
                late_free[s] <= late_free[s-1];
                late_comp[s] <= late_comp[s-1];
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mask_ready_dep <= 1'b0;
        end else begin
            mask_ready_dep <= late_free[DEP_LEN-1];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dest_ready <= 1'b0;
        end else begin
            dest_ready <= late_free[DEST_LEN-1] && late_comp[DEST_LEN-1];
        end
    end

endmodule

//--- design/vmcu_pkg.sv
/*
 * Constants, field positions and timing figures of the vector mask and
 * compress unit. Assumes a single clock at 250 MHz and that all figures
 * are counted in clock periods of that clock.
 */
// Functional notes
// - Mask MSB is element 0, LSB element 63.
// - Low two designator bits pick the element test.
// - Designator high bit enables compress index output.
// - Sign bit alone decides positive or negative.
// - Mask bit set on hit, cleared on miss.
// - Compress form builds the same mask.
// - Index written and pointer advanced only on hits.
// - Test element count; untested mask bits zero.
// - No hits means zero mask, no writes.
// - One-period issue; source freed at count plus three.
// - Destination ready at count plus ten.
// - Mask ready count plus four; dependent plus five.
// - Elements advance only as source data arrives.
package vmcu_pkg;

    localparam int VMCU_ELEM_W = 64;
    localparam int VMCU_CNT_W  = 7;
    localparam int VMCU_IDX_W  = 6;
    localparam int VMCU_TIME_W = 8;
    localparam int VMCU_SIGN_BIT     = 63;
    localparam int VMCU_COMPRESS_BIT = 2;

    localparam logic [1:0] VMCU_TEST_ZERO    = 2'h0;
    localparam logic [1:0] VMCU_TEST_NONZERO = 2'h1;
    localparam logic [1:0] VMCU_TEST_POS     = 2'h2;
    localparam logic [1:0] VMCU_TEST_NEG     = 2'h3;

    // Latencies beyond the element count, in clock periods.
    localparam logic [VMCU_TIME_W-1:0] VMCU_ISSUE_CP      = 8'h01;
    localparam logic [VMCU_TIME_W-1:0] VMCU_SRC_FREE_CP   = 8'h03;
    localparam logic [VMCU_TIME_W-1:0] VMCU_UNIT_FREE_CP  = 8'h04;
    localparam logic [VMCU_TIME_W-1:0] VMCU_MASK_RDY_CP   = 8'h04;
    localparam logic [VMCU_TIME_W-1:0] VMCU_MASK_DEP_CP   = 8'h05;
    localparam logic [VMCU_TIME_W-1:0] VMCU_DEST_RDY_CP   = 8'h0A;

    localparam logic [VMCU_ELEM_W-1:0] VMCU_MASK_RESET = 64'h0;
    localparam logic [VMCU_CNT_W-1:0]  VMCU_CNT_RESET  = 7'h00;
    localparam logic [VMCU_TIME_W-1:0] VMCU_TIME_RESET = 8'h00;

    typedef enum logic [1:0] {
        VMCU_IDLE,
        VMCU_SCAN,
        VMCU_DRAIN
    } vmcu_state_e;

endpackage

//--- design/vmcu_test_if.sv
/*
 * Carrier between the unit's sequencer and its element tester.
 * Assumes both ends sit in the same clock domain; the path is combinational.
 */
`timescale 1ns/1ps

interface vmcu_test_if;
    logic [63:0] element;
    logic [1:0]  test;
    logic        hit;

    modport sequencer (output element, output test, input hit);
    modport tester    (input element, input test, output hit);
endinterface

//--- test/tb_vmcu_mask_compress.sv
/* Self-checking bench for the mask and compress unit.
   Assumes the unit and its source model share one clock. */
`timescale 1ns/1ps

module tb_vmcu_mask_compress;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        issue_valid = 1'b0;
    logic        stall = 1'b0;
    logic [2:0]  desig = 3'h0;
    logic [6:0]  count = 7'h00;
    logic [63:0] elems [64];
    logic        issue_ready, src_valid, src_ready, src_release, idx_wr_en, dest_ready;
    logic        mask_ready, mask_ready_dep;
    logic [5:0]  src_index, idx_wr_addr;
    logic [63:0] data, idx_data, mask;
    logic [63:0] mq [$];
    logic [63:0] iq [$];
    int          bad_count = 0;
    int          num_checks = 0;
    logic [31:0] seed = 32'h4727;
    always #2 clock = ~clock;
    vmcu_mask_compress uut (.clock(clock), .reset_n(reset_n), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .issue_designator(desig), .element_count_register(count),
        .src_valid(src_valid), .src_ready(src_ready), .tested_source_vector(data),
        .src_index(src_index), .src_release(src_release), .idx_wr_en(idx_wr_en),
        .idx_wr_addr(idx_wr_addr), .index_destination_vector(idx_data),
        .dest_ready(dest_ready), .element_flag_register(mask), .mask_ready(mask_ready),
        .mask_ready_dep(mask_ready_dep));
    vmcu_src_model model (.clock(clock), .reset_n(reset_n), .stall(stall),
        .src_ready(src_ready), .src_index(src_index), .elems(elems), .src_valid(src_valid),
        .tested_source_vector(data));
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    function automatic logic hit(input logic [1:0] t, input logic [63:0] e);
        case (t)
            2'h0: return e == 64'h0;
            2'h1: return e != 64'h0;
            2'h2: return !e[63];
            default: return e[63];
        endcase
    endfunction
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic run(input logic [2:0] d, input logic [6:0] n, input logic st, input logic nh);
        logic [63:0] m;
        logic [5:0]  p;
        int          cyc;
        int          rel;
        int          dep;
        int          dst;
        m = 64'h0;
        p = 6'h00;
        for (int k = 0; k < 64; k++) begin
            seed = xs(seed);
            elems[k] = nh ? {33'h0, seed[30:0]} | 64'h1
                          : seed[1:0] == 2'h0 ? 64'h0 : {seed[0], 31'h0, seed};
            if (k < n && hit(d[1:0], elems[k])) begin
                m[63-k] = 1'b1;
                if (d[2]) iq.push_back({p, 52'h0, 6'(k)});
                if (d[2]) p++;
            end
        end
        mq.push_back(m);
        stall = st;
        desig = d;
        count = n;
        issue_valid = 1'b1;
        @(negedge clock);
        issue_valid = 1'b0;
        // The issue edge closes cycle zero, so this falling edge lies in cycle one.
        cyc = 1;
        rel = 0;
        dep = 0;
        dst = 0;
        while (mask_ready !== 1'b1 && cyc < 300) begin
            if (src_release === 1'b1) rel = cyc;
            @(negedge clock);
            cyc++;
        end
        if (!st) check(64'(cyc), 64'(n) + 64'h4);
        if (!st) check(64'(rel), 64'(n) + 64'h3);
        for (int j = 1; j <= 8; j++) begin
            @(negedge clock);
            if (mask_ready_dep === 1'b1) dep = j;
            if (dest_ready === 1'b1) dst = j;
        end
        check(64'(dep), 64'h1);
        check(64'(dst), d[2] ? 64'h6 : 64'h0);
    endtask
    always @(negedge clock) begin
        if (idx_wr_en === 1'b1)
            check({idx_wr_addr, idx_data[57:0]}, iq.size() ? iq.pop_front() : '1);
        if (mask_ready === 1'b1)
            check(mask, mq.size() ? mq.pop_front() : '1);
    end
    initial begin
        #20000;
        bad_count++;
        wrap_up();
    end
    initial begin
        for (int k = 0; k < 64; k++) elems[k] = 64'h0;
        repeat (12) @(negedge clock);
        reset_n = 1'b1;
        @(negedge clock);
        // Last two runs can match nothing, so no index write may appear.
        for (int t = 0; t < 14; t++) begin
            seed = xs(seed);
            run(t == 13 ? 3'h7 : t == 12 ? 3'h4 : 3'(t),
                t == 8 ? 7'h40 : t == 9 ? 7'h00 : 7'(seed[4:0]) + 7'h01, t[1], t > 11);
        end
        check(64'(iq.size() + mq.size()), 64'h0);
        wrap_up();
    end
endmodule

//--- test/vmcu_mask_compress_assertions.sv
/* Port checker for the mask and compress unit.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps

module vmcu_mask_compress_assertions (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        issue_valid,
    input wire logic        issue_ready,
    input wire logic [2:0]  issue_designator,
    input wire logic        src_valid,
    input wire logic        src_ready,
    input wire logic [5:0]  src_index,
    input wire logic        src_release,
    input wire logic        idx_wr_en,
    input wire logic [5:0]  idx_wr_addr,
    input wire logic [63:0] index_destination_vector,
    input wire logic        dest_ready,
    input wire logic [63:0] element_flag_register,
    input wire logic        mask_ready,
    input wire logic        mask_ready_dep
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic       comp;
    logic [5:0] wptr;
    wire        take = issue_valid && issue_ready;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) comp <= 1'b0;
        else if (take) comp <= issue_designator[2];
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) wptr <= 6'h00;
        else if (take) wptr <= 6'h00;
        else if (idx_wr_en) wptr <= wptr + 6'h01;
    end
    a_issue_busy: assert property (take |=> !issue_ready)
        else $error("unit stayed free after issue");
    a_unit_free: assert property (mask_ready |-> issue_ready)
        else $error("unit busy at mask ready");
    a_src_before_mask: assert property (src_release |=> mask_ready)
        else $error("source release not one cycle before mask ready");
    a_dep_after_mask: assert property (mask_ready |=> mask_ready_dep)
        else $error("dependent ready not one cycle after mask ready");
    a_dest_lag: assert property (mask_ready && comp |-> ##6 dest_ready)
        else $error("destination ready late or missing");
    a_dest_compress: assert property (dest_ready |-> $past(mask_ready && comp, 6))
        else $error("destination ready on plain mask form");
    a_idx_compress: assert property (idx_wr_en |-> comp)
        else $error("index write on plain mask form");
    a_ptr_order: assert property (idx_wr_en |-> idx_wr_addr == wptr)
        else $error("write pointer out of order");
    a_idx_value: assert property (idx_wr_en |-> $past(src_valid && src_ready)
        && index_destination_vector == {58'h0, $past(src_index)})
        else $error("index value differs from tested element");
    a_mask_clear: assert property (take |=> element_flag_register == 64'h0)
        else $error("mask not cleared at issue");
    c_dest: cover property (dest_ready);
    c_stall: cover property (src_ready && !src_valid);
    c_burst: cover property (idx_wr_en ##1 idx_wr_en);
endmodule

bind vmcu_mask_compress vmcu_mask_compress_assertions chk (.clock(clock), .reset_n(reset_n),
    .issue_valid(issue_valid), .issue_ready(issue_ready), .issue_designator(issue_designator),
    .src_valid(src_valid), .src_ready(src_ready), .src_index(src_index),
    .src_release(src_release), .idx_wr_en(idx_wr_en), .idx_wr_addr(idx_wr_addr),
    .index_destination_vector(index_destination_vector), .dest_ready(dest_ready),
    .element_flag_register(element_flag_register), .mask_ready(mask_ready),
    .mask_ready_dep(mask_ready_dep));

//--- test/vmcu_src_model.sv
/* Source register file model that streams elements to the unit.
   Assumes the bench fills elems while the unit is idle. */
`timescale 1ns/1ps

module vmcu_src_model (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        stall,
    input  wire logic        src_ready,
    input  wire logic [5:0]  src_index,
    input  logic      [63:0] elems [64],
    output logic             src_valid,
    output logic      [63:0] tested_source_vector
);
    logic [1:0] beat = 2'h0;
    logic       nv;
    initial src_valid = 1'b0;
    initial tested_source_vector = 64'h0;
    // An offered element is held until taken; gaps only start between elements.
    always @(negedge clock) begin
        beat <= beat + 2'h1;
        if (src_valid && !src_ready) nv = 1'b1;
        else nv = reset_n && !(stall && beat == 2'h0);
        src_valid <= nv;
        tested_source_vector <= nv ? elems[src_index] : ~tested_source_vector;
    end
endmodule
